// File: design/dma_channels.sv
// Seven DMA channel register banks, main enable and one address mover shared by all channels.
// Assumes an APB master, packet data from flow-control masters on the same clock,
// and a memory sink that takes one packet per accepted beat.
`include "dma_defs.svh"

module dma_channels
   import dma_pkg::*;
#(
   parameter int ADDR_WIDTH = 32,
   parameter int NCHAN      = `CHAN_COUNT,
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  req_channel,
   input  wire logic        req_valid,
   input  wire logic [31:0] req_data,
   output logic             req_ready,
   output logic             req_done,
   output logic      [2:0]  done_channel,
   output logic      [31:0] mem_addr,
   output logic      [31:0] mem_data,
   output logic      [2:0]  mem_size,
   output logic             mem_valid,
   input  wire logic        mem_ready,
   output logic      [NCHAN-1:0] chan_running
);
   localparam logic [31:0] AMASK = (ADDR_WIDTH >= 32) ? 32'hFFFF_FFFF :
                                   ((32'h1 << ADDR_WIDTH) - 32'h1);
   // Bank span and packet layout; CH_W follows the 3-bit channel ports
   localparam logic [31:0] BANK_SPAN = (32'h1 << `CHAN_STRIDE_LOG) - 32'h1;
   localparam logic [28:0] MAIN_HI   = 29'(`MAIN_BASE >> 3);
   localparam int          CH_W      = 3;
   localparam int          PKT_W     = 32 + CH_W;
   localparam int          FW        = $clog2(FIFO_DEPTH) + 1;

   typedef struct packed {
      logic             main_enable;
      logic [NCHAN-1:0] chan_enable;
      logic [NCHAN-1:0][31:0] mem_start;
      logic [NCHAN-1:0][31:0] mem_end;
      logic [NCHAN-1:0][31:0] periph_addr;
      logic [NCHAN-1:0][31:0] control;
      logic [NCHAN-1:0][31:0] irq_status;
      logic [NCHAN-1:0][31:0] irq_enable;
      logic             ck_enable;
      logic [31:0]      ck_value;
      logic [31:0]      ck_post;
      logic [31:0]      packet;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic             req_done;
      logic [2:0]       done_channel;
      logic [31:0]      mem_addr;
      logic [31:0]      mem_data;
      logic [2:0]       mem_size;
      logic             mem_valid;
      logic [NCHAN-1:0] running;
      move_state_t      move_state;
      logic [FW-1:0]    fill;
      logic             req_ready;
   } dma_state_t;

   dma_state_t       state_reg;
   dma_state_t       state_next;
   logic [PKT_W-1:0] fifo_in;
   logic [PKT_W-1:0] fifo_out;
   logic             fifo_in_ready;
   logic             fifo_out_valid;
   logic             fifo_out_ready;
   logic             fifo_push;
   logic             q_push;
   logic             q_pop;

   // Packet data with its channel queues here so masters see back-pressure
   assign fifo_in   = {req_channel, req_data};
   assign fifo_push = req_valid && (int'(req_channel) < NCHAN)
                      && state_reg.running[req_channel];
   assign req_ready = state_reg.req_ready;

   // Queue traffic, counted here so req_ready leaves a flip-flop
   assign q_push    = fifo_push && fifo_in_ready;
   assign q_pop     = fifo_out_valid && fifo_out_ready;

   dma_fifo #(
      .WIDTH (PKT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_data   (fifo_in),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready)
   );

   // The mover takes one beat only when idle, so one packet is in flight
   assign fifo_out_ready = (state_reg.move_state == ST_IDLE);

   function automatic logic [31:0] ck_step(input logic [31:0] crc, input logic [31:0] d);
      logic [31:0] c;
      c = crc;
      for (int i = 0; i < 32; i++) begin
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ `CK_POLY) : (c >> 1);
      end
      return c;
   endfunction : ck_step

   always_comb begin
      logic [31:0] off_addr;
      logic [2:0]  ch;
      logic [5:0]  off;
      logic        in_chan;
      logic        in_main;
      logic [31:0] rdata;
      logic        apb_go;
      logic [2:0]  mch;
      logic [31:0] size;
      logic [31:0] next_mem;
      logic        ck_bank;
      off_addr   = 32'h0;
      ch         = 3'h0;
      off        = 6'h0;
      rdata      = 32'h0;
      mch        = 3'h0;
      size       = 32'h0;
      next_mem   = 32'h0;
      in_chan    = 1'b0;
      in_main    = 1'b0;
      apb_go     = 1'b0;
      ck_bank    = 1'b0;

      state_next = state_reg;
      state_next.req_done  = 1'b0;
      state_next.pready    = 1'b0;
      state_next.pslverr   = 1'b0;

      // Bank select: 40h stride from channel 0 base
      off_addr = paddr - `CHAN_BASE;
      ch       = off_addr[CH_W+`CHAN_STRIDE_LOG-1:`CHAN_STRIDE_LOG];
      off      = off_addr[`CHAN_STRIDE_LOG-1:0];
      ck_bank  = (ch == `CK_CHANNEL);
      in_chan  = (paddr >= `CHAN_BASE) && (paddr <= (`CHAN_LAST_BASE + BANK_SPAN))
                 && (int'(ch) < NCHAN);
      in_main  = (paddr[31:3] == MAIN_HI);
      apb_go   = psel && penable && !state_reg.pready;

      if (apb_go) begin
         state_next.pready = 1'b1;
         if (in_main) begin
            if (paddr[7:0] == `MAIN_CONTROL_OFF) begin
               rdata = {31'h0, state_reg.main_enable};
               if (pwrite) begin
                  state_next.main_enable = pwdata[0];
               end
            end else begin
               rdata = state_reg.packet;
            end
         end else if (in_chan) begin
            unique case (off)
               `OFF_ENABLE: begin
                  rdata = {31'h0, state_reg.chan_enable[ch]};
                  if (pwrite) begin
                     state_next.chan_enable[ch] = pwdata[0];
                  end
               end
               `OFF_MEM_START: begin
                  rdata = state_reg.mem_start[ch];
                  if (pwrite) begin
                     state_next.mem_start[ch] = pwdata & AMASK;
                  end
               end
               `OFF_MEM_END: begin
                  rdata = state_reg.mem_end[ch];
                  if (pwrite) begin
                     state_next.mem_end[ch] = pwdata & AMASK;
                  end
               end
               `OFF_PERIPH_ADDR: begin
                  rdata = state_reg.periph_addr[ch];
                  if (pwrite) begin
                     state_next.periph_addr[ch] = pwdata & AMASK;
                  end
               end
               `OFF_CONTROL: begin
                  rdata = state_reg.control[ch];
                  if (pwrite) begin
                     state_next.control[ch] = pwdata & `CTRL_WMASK;
                  end
               end
               `OFF_IRQ_STATUS: begin
                  rdata = state_reg.irq_status[ch];
                  // A done raised by the mover in this cycle wins over the clear
                  if (pwrite) begin
                     state_next.irq_status[ch] = state_reg.irq_status[ch] & ~pwdata;
                  end
               end
               `OFF_IRQ_ENABLE: begin
                  rdata = state_reg.irq_enable[ch];
                  if (pwrite) begin
                     state_next.irq_enable[ch] = pwdata;
                  end
               end
               `OFF_CK_ENABLE: begin
                  if (ck_bank) begin
                     rdata = {31'h0, state_reg.ck_enable};
                     if (pwrite) begin
                        state_next.ck_enable = pwdata[0];
                     end
                  end
               end
               `OFF_CK_VALUE: begin
                  if (ck_bank) begin
                     rdata = state_reg.ck_value;
                     if (pwrite) begin
                        state_next.ck_value = pwdata;
                     end
                  end
               end
               `OFF_CK_POST: begin
                  if (ck_bank) begin
                     rdata = state_reg.ck_post;
                     if (pwrite) begin
                        state_next.ck_post = state_reg.ck_post & ~pwdata;
                     end
                  end
               end
               `OFF_TEST: begin
                  rdata = 32'h0;
               end
               `OFF_CK_TEST: begin
                  rdata = 32'h0;
               end
               default: begin
                  rdata = 32'h0;
               end
            endcase
         end else begin
            state_next.pslverr = 1'b1;
         end
         if (!pwrite) begin
            state_next.prdata = rdata;
         end
      end

      // A channel runs only with both enables set
      for (int i = 0; i < NCHAN; i++) begin
         state_next.running[i] = state_next.main_enable && state_next.chan_enable[i];
      end

      // Mirror of the queue fill; it equals the queue's own count every cycle
      state_next.fill      = state_reg.fill + FW'(q_push) - FW'(q_pop);
      state_next.req_ready = (state_next.fill != FW'(FIFO_DEPTH));

      // Memory mover: the start address is the slave endpoint
      unique case (state_reg.move_state)
         ST_IDLE: begin
            if (fifo_out_valid) begin
               mch  = fifo_out[PKT_W-1:PKT_W-CH_W];
               size = {29'h0, state_reg.control[mch][`CTRL_SIZE_HI:`CTRL_SIZE_LO]};
               state_next.packet   = fifo_out[31:0];
               state_next.mem_size = size[2:0];
               state_next.done_channel = mch;
               // A packet for a stopped channel is dropped, not held back
               if (!state_reg.running[mch]) begin
                  state_next.move_state = ST_IDLE;
               end else if (state_reg.mem_start[mch] < state_reg.mem_end[mch]) begin
                  state_next.mem_addr   = state_reg.mem_start[mch];
                  state_next.mem_data   = fifo_out[31:0];
                  state_next.mem_valid  = 1'b1;
                  state_next.move_state = ST_MOVE;
               end else begin
                  state_next.move_state = ST_DONE;
               end
            end
         end
         ST_MOVE: begin
            mch = state_reg.done_channel;
            if (mem_ready) begin
               state_next.mem_valid  = 1'b0;
               state_next.move_state = ST_IDLE;
               size = {29'h0, state_reg.mem_size};
               // The mover's update wins over a software write in the same cycle
               if (state_reg.control[mch][`CTRL_INC_MEM]) begin
                  next_mem = (state_reg.mem_start[mch] + size) & AMASK;
                  state_next.mem_start[mch] = next_mem;
               end
               if (state_reg.control[mch][`CTRL_INC_PERIPH]) begin
                  state_next.periph_addr[mch] = (state_reg.periph_addr[mch] + size) & AMASK;
               end
               // Checksum only on channel 0, full-word packets only
               if (mch == `CK_CHANNEL && state_reg.ck_enable && size == 32'h4) begin
                  state_next.ck_value = ck_step(state_reg.ck_value, state_reg.mem_data);
               end
            end
         end
         ST_DONE: begin
            // The ending packet is not written; only completion is reported
            mch = state_reg.done_channel;
            state_next.req_done = 1'b1;
            state_next.irq_status[mch][`STAT_DONE] = 1'b1;
            state_next.move_state = ST_IDLE;
         end
         default: begin
            state_next.move_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg            <= '0;
         state_reg.move_state <= ST_IDLE;
         state_reg.mem_start  <= {NCHAN{`ADDR_RESET}};
         // Queue starts empty, so the packet port is ready out of reset
         state_reg.req_ready  <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata       = state_reg.prdata;
   assign pready       = state_reg.pready;
   assign pslverr      = state_reg.pslverr;
   assign req_done     = state_reg.req_done;
   assign done_channel = state_reg.done_channel;
   assign mem_addr     = state_reg.mem_addr;
   assign mem_data     = state_reg.mem_data;
   assign mem_size     = state_reg.mem_size;
   assign mem_valid    = state_reg.mem_valid;
   assign chan_running = state_reg.running;
endmodule : dma_channels

// File: design/dma_defs.svh
// Constants and register map for the seven-channel DMA register block.
// Assumes an APB master with 32-bit data and a single 100 MHz clock.
//
// Behaviour
// - Channel banks at 2440h, stride 40h, to 25C0h
// - Same register set per channel, own base
// - Checksum hardware only on channel 0
// - Checksum registers 20h-2Ch decoded only channel 0
// - Enable bit 0 read-write, resets 0, 7:1 reserved
// - Channel runs only with own and global enable
// - Add transfer size after each packet when incrementing
// - Memory start address names the slave endpoint
// - Memory start 32-bit read-write, resets to zero
// - Address fields as wide as system address bus
// - Run below end address, signal done at it
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

`define MAIN_BASE        32'h0000_2400
`define MAIN_CONTROL_OFF 8'h00
`define MAIN_PACKET_OFF  8'h04
`define CHAN_BASE        32'h0000_2440
`define CHAN_LAST_BASE   32'h0000_25C0
`define CHAN_STRIDE_LOG  6
`define CHAN_COUNT       7
`define OFF_ENABLE       6'h00
`define OFF_MEM_START    6'h04
`define OFF_MEM_END      6'h08
`define OFF_PERIPH_ADDR  6'h0C
`define OFF_CONTROL      6'h10
`define OFF_IRQ_STATUS   6'h14
`define OFF_IRQ_ENABLE   6'h18
`define OFF_TEST         6'h1C
`define OFF_CK_ENABLE    6'h20
`define OFF_CK_VALUE     6'h24
`define OFF_CK_POST      6'h28
`define OFF_CK_TEST      6'h2C
`define CTRL_INC_MEM     16
`define CTRL_INC_PERIPH  17
`define CTRL_SIZE_LO     20
`define CTRL_SIZE_HI     22
`define CTRL_GO          24
`define CTRL_ABORT       25
`define CTRL_WMASK       32'h0377_0000
`define STAT_DONE        0
`define ADDR_RESET       32'h0000_0000
`define CK_POLY          32'hEDB8_8320
`define CK_CHANNEL       3'h0

`endif

// File: design/dma_fifo.sv
// Small data FIFO between the packet source and the sink.
// Assumes one clock; both sides use valid/ready.
module dma_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
   } fifo_state_t;
   fifo_state_t            state_reg;
   fifo_state_t            state_next;
   logic [WIDTH-1:0]       mem [DEPTH];
   logic                   push;
   logic                   pop;

   assign in_ready  = (state_reg.count != (AW+1)'(DEPTH));
   assign out_valid = (state_reg.count != '0);
   assign out_data  = mem[state_reg.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      state_next = state_reg;
      if (push) begin
         state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : state_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : state_reg.rd_ptr + 1'b1;
      end
      state_next.count = state_reg.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[state_reg.wr_ptr] <= in_data;
      end
   end
endmodule : dma_fifo

// File: design/dma_pkg.sv
// Types shared by the DMA register block.
// Assumes dma_defs.svh for all numeric constants.
package dma_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MOVE = 2'b01,
      ST_DONE = 2'b10
   } move_state_t;
endpackage : dma_pkg

// File: verification/dma_channel_register_map_bench.sv
// Bench for the DMA channel register block.
// Assumes dma_channels, its checker and mem_sink are compiled first.
module dma_channel_register_map_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, req_data, mem_addr, mem_data;
   logic [2:0]  req_channel, done_channel, mem_size, msize, done_ch;
   logic        req_valid, req_ready, req_done, mem_valid, mem_ready, stall, slow;
   logic [6:0]  chan_running;
   logic [31:0] beat_q[$];
   logic [31:0] data_q[$];
   int          err_count, cmp_count, done_n, cyc;
   dma_channels DUT (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .req_channel, .req_valid, .req_data, .req_ready,
      .req_done, .done_channel, .mem_addr, .mem_data, .mem_size, .mem_valid,
      .mem_ready, .chan_running);
   mem_sink sink (.mclk, .reset_n, .stall, .slow, .mem_ready);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
         beat_q.push_back(mem_addr);
         data_q.push_back(mem_data);
         msize = mem_size;
      end
      if (req_done === 1'b1) begin
         done_n++;
         done_ch = done_channel;
      end
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   function automatic logic [31:0] ca(input int ch, input logic [7:0] off);
      return 32'h0000_2440 + 32'(ch) * 32'h40 + {24'h0, off};
   endfunction : ca
   // Holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
      chk("apb answer", 32'h1, 32'(n < 50));
   endtask : apb
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk($sformatf("read %h", a), x, r);
      chk($sformatf("error %h", a), {31'h0, xe}, {31'h0, e});
   endtask : rd
   task automatic push(input logic [2:0] ch, input logic [31:0] d);
      int n;
      n = 0;
      req_channel <= ch;
      req_data <= d;
      req_valid <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      @(posedge mclk);
      chk("push taken", 32'h1, 32'(n < 50));
   endtask : push
   task automatic wait_beats(input int n);
      int k;
      k = 0;
      while (beat_q.size() < n && k < 200) begin
         @(posedge mclk);
         k++;
      end
      chk("beat count", 32'(n), 32'(beat_q.size()));
   endtask : wait_beats
   task automatic t_reset();
      for (int c = 0; c < 7; c++) begin
         rd(ca(c, 8'h00), 32'h0, 1'b0);
         rd(ca(c, 8'h04), 32'h0, 1'b0);
      end
      $display("test reset done");
   endtask : t_reset
   task automatic t_map();
      for (int c = 0; c < 7; c++)
         wr(ca(c, 8'h04), 32'hA5A5_0000 | 32'(c));
      for (int c = 0; c < 7; c++)
         rd(ca(c, 8'h04), 32'hA5A5_0000 | 32'(c), 1'b0);
      wr(ca(6, 8'h08), 32'h1234_5678);
      rd(ca(6, 8'h08), 32'h1234_5678, 1'b0);
      wr(ca(6, 8'h0C), 32'hFEDC_BA98);
      rd(ca(6, 8'h0C), 32'hFEDC_BA98, 1'b0);
      wr(ca(6, 8'h00), 32'hFFFF_FFFF);
      rd(ca(6, 8'h00), 32'h1, 1'b0);
      wr(ca(6, 8'h00), 32'h0);
      $display("test map done");
   endtask : t_map
   task automatic t_ck();
      wr(ca(0, 8'h24), 32'hFFFF_FFFF);
      rd(ca(0, 8'h24), 32'hFFFF_FFFF, 1'b0);
      wr(ca(3, 8'h24), 32'hFFFF_FFFF);
      rd(ca(3, 8'h24), 32'h0, 1'b0);
      wr(ca(1, 8'h20), 32'h1);
      rd(ca(1, 8'h20), 32'h0, 1'b0);
      rd(32'h0000_3000, 32'h0, 1'b1);
      $display("test checksum done");
   endtask : t_ck
   task automatic t_enable();
      wr(ca(1, 8'h00), 32'h1);
      repeat (3) @(posedge mclk);
      chk("running alone", 32'h0, {25'h0, chan_running});
      wr(32'h0000_2400, 32'h1);
      repeat (3) @(posedge mclk);
      chk("running both", 32'h2, {25'h0, chan_running});
      wr(ca(1, 8'h00), 32'h0);
      repeat (3) @(posedge mclk);
      chk("running off", 32'h0, {25'h0, chan_running});
      $display("test enable done");
   endtask : t_enable
   task automatic t_move();
      int k;
      beat_q.delete();
      data_q.delete();
      done_n = 0;
      wr(ca(2, 8'h04), 32'h100);
      wr(ca(2, 8'h08), 32'h108);
      wr(ca(2, 8'h10), 32'h0041_0000);
      wr(ca(2, 8'h00), 32'h1);
      for (int i = 0; i < 3; i++)
         push(3'h2, 32'(i));
      wait_beats(2);
      k = 0;
      while (done_n == 0 && k < 50) begin
         @(posedge mclk);
         k++;
      end
      chk("beats", 32'h2, 32'(beat_q.size()));
      chk("first", 32'h100, beat_q[0]);
      chk("second", 32'h104, beat_q[1]);
      chk("done ch", 32'h2, {29'h0, done_ch});
      chk("done count", 32'h1, 32'(done_n));
      chk("first data", 32'h0, data_q[0]);
      chk("second data", 32'h1, data_q[1]);
      rd(ca(2, 8'h04), 32'h108, 1'b0);
      $display("test move done");
   endtask : t_move
   task automatic t_noinc();
      beat_q.delete();
      wr(ca(4, 8'h04), 32'h200);
      wr(ca(4, 8'h08), 32'h300);
      wr(ca(4, 8'h10), 32'h0020_0000);
      wr(ca(4, 8'h00), 32'h1);
      push(3'h4, 32'h11);
      push(3'h4, 32'h22);
      wait_beats(2);
      chk("held addr", 32'h200, beat_q[1]);
      chk("size", 32'h2, {29'h0, msize});
      $display("test hold done");
   endtask : t_noinc
   task automatic t_fill();
      int n;
      int k;
      beat_q.delete();
      wr(ca(5, 8'h04), 32'h400);
      wr(ca(5, 8'h08), 32'h1000);
      wr(ca(5, 8'h10), 32'h0041_0000);
      wr(ca(5, 8'h00), 32'h1);
      stall <= 1'b1;
      req_channel <= 3'h5;
      req_valid <= 1'b1;
      n = 0;
      k = 0;
      while (k < 12) begin
         @(posedge mclk);
         k++;
         if (req_ready !== 1'b1)
            break;
         req_data <= 32'(k);
         n++;
      end
      req_valid <= 1'b0;
      chk("refused", 32'h1, 32'(k < 12 && n == 5));
      stall <= 1'b0;
      slow <= 1'b1;
      wait_beats(n);
      for (int i = 0; i < n; i++)
         chk("fill addr", 32'h400 + 32'(4 * i), beat_q[i]);
      slow <= 1'b0;
      $display("test fill done");
   endtask : t_fill
   initial begin
      {psel, penable, pwrite, req_valid, stall, slow} = 6'h0;
      {paddr, pwdata, req_data} = 96'h0;
      req_channel = 3'h0;
      reset_n = 1'b0;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_map();
      t_ck();
      t_enable();
      t_move();
      t_noinc();
      t_fill();
      test_done();
   end
endmodule : dma_channel_register_map_bench

// File: verification/dma_channels_asserts.sv
// Port assertions for the DMA channel register block.
// Assumes one clock and an asynchronous active-low reset.
module dma_channels_asserts #(
   parameter int NCHAN = 7
) (
   input wire logic             mclk,
   input wire logic             reset_n,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic             req_done,
   input wire logic [31:0]      mem_addr,
   input wire logic             mem_valid,
   input wire logic             mem_ready,
   input wire logic [NCHAN-1:0] chan_running
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   sequence apb_access;
      psel && penable && !pready;
   endsequence
   sequence beat_wait;
      mem_valid && !mem_ready;
   endsequence
   apb_answer_a: assert property (apb_access |=> pready)
      else $error("pready not one cycle after access");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("pready without access phase");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   beat_hold_a: assert property (beat_wait |=> mem_valid && $stable(mem_addr))
      else $error("memory beat dropped or changed before taken");
   beat_release_a: assert property ($fell(mem_valid) |-> $past(mem_ready))
      else $error("memory beat withdrawn without ready");
   done_pulse_a: assert property (req_done |=> !req_done)
      else $error("done longer than one cycle");
   running_cause_a: assert property ($changed(chan_running) |->
      $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
      else $error("running set changed without register write");
endmodule : dma_channels_asserts

bind dma_channels dma_channels_asserts #(.NCHAN(NCHAN)) chk (.mclk, .reset_n, .psel,
   .penable, .pwrite, .pready, .pslverr, .req_done, .mem_addr, .mem_valid, .mem_ready,
   .chan_running);

// File: verification/mem_sink.sv
// Memory model taking write beats from the address mover.
// Assumes beats stay valid until ready is seen at an edge.
module mem_sink (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic stall,
   input  wire logic slow,
   output logic      mem_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   // Slave endpoint: takes beats, never starts them; slow mode every third cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         cnt <= 2'h0;
      else
         cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
   end
   assign mem_ready = !stall && (!slow || cnt == 2'h0);
endmodule : mem_sink
